//--- rtl/fpec_dev.sv
// flash program and erase controller: enables, key lock, timed operations
// Function
// [RL1] program one byte from write operands
// [RL2] programming only clears bits
// [RL3] operations timed internally
// [RL4] core stalled during flash operation
// [RL5] write enable steers writes to flash
// [RL6] write enable cleared only by software
// [RL7] unsafe supply monitor causes error reset
// [RL8] unlock needs first then second key
// [RL9] wrong or misordered key locks out
// [RL10] operation before unlock locks out
// [RL11] lock rearms after each operation
// [RL12] erase clears whole 1024-byte page
// [RL13] erase write targets page, data ignored
// [RL14] software follows guided erase order
// [RL15] software selects bank before access
// [RL16] debug path programs without key
// [RL17] software enables monitor and reset together
// [RL18] erase needs both enables set
// [RL19] data reads always hit ram
// [RL20] key machine with sticky lockout state
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "fpec_map.svh"
module fpec_dev #(
   parameter int ERASE_CYCLES = `FPEC_ERASE_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   fpec_if.dev ifc,
   output logic [16:0] fl_addr,
   output logic [7:0] fl_wdata,
   output logic fl_prog,
   output logic fl_erase,
   input wire logic [7:0] fl_rdata,
   output logic [15:0] ram_addr,
   output logic [7:0] ram_wdata,
   output logic ram_we,
   output logic ram_re,
   input wire logic [7:0] ram_rdata,
   output logic flash_error_reset
);
   localparam logic [20:0] PROG_CNT = 21'(`FPEC_PROG_CYCLES);
   localparam logic [20:0] ERASE_CNT = 21'(ERASE_CYCLES);
   localparam logic [16:0] PAGE_MASK = ~17'((1 << `FPEC_PAGE_BITS) - 1);

   fpec_pkg::fpec_dev_t q, d;

   // upper half of the core space is banked, lower half is common
   function automatic logic [16:0] map_addr(input logic [1:0] bank, input logic [15:0] a);
      return a[15] ? {bank, a[14:0]} : {2'b00, a[14:0]};
   endfunction : map_addr

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.ack = 1'b0;
      d.dbg_ack = 1'b0;
      d.rwe = 1'b0;
      d.rre = 1'b0;
      d.err = 1'b0;
      unique case (q.op)
         fpec_pkg::OP_IDLE:
         begin
            // [RL16] debug bypasses key
            if (ifc.dbg_req && !q.dbg_ack)
            begin
               d.dbg = 1'b1;
               d.fd = ifc.dbg_data;
               if (ifc.dbg_erase)
               begin
                  d.fa = ifc.dbg_addr & PAGE_MASK;
                  d.erase = 1'b1;
                  d.cnt = ERASE_CNT;
                  d.op = fpec_pkg::OP_ERASE;
               end
               else
               begin
                  d.fa = ifc.dbg_addr;
                  d.op = fpec_pkg::OP_RDOLD;
               end
            end
            else if (ifc.req && !q.ack)
            begin
               if (ifc.sfr)
               begin
                  d.ack = 1'b1;
                  d.rdata = 8'h00;
                  unique case (ifc.addr)
                     `FPEC_SFR_CONTROL:
                     begin
                        d.rdata = {6'h00, q.een, q.wen};
                        // [RL6] software alone clears enable
                        if (ifc.we)
                        begin
                           d.wen = ifc.wdata[`FPEC_WE_BIT];
                           d.een = ifc.wdata[`FPEC_EE_BIT];
                        end
                     end
                     `FPEC_SFR_KEY:
                     begin
                        d.rdata = {6'h00, q.key};
                        if (ifc.we)
                        begin
                           // [RL8] ordered two-code unlock
                           // [RL9] bad code locks out
                           // [RL20] lockout is sticky
                           unique case (q.key)
                              fpec_pkg::KEY_LOCKED:
                                 d.key = (ifc.wdata == `FPEC_KEY_FIRST) ?
                                         fpec_pkg::KEY_FIRST : fpec_pkg::KEY_LOCKOUT;
                              fpec_pkg::KEY_FIRST:
                                 d.key = (ifc.wdata == `FPEC_KEY_SECOND) ?
                                         fpec_pkg::KEY_UNLOCKED : fpec_pkg::KEY_LOCKOUT;
                              fpec_pkg::KEY_UNLOCKED: d.key = fpec_pkg::KEY_LOCKOUT;
                              fpec_pkg::KEY_LOCKOUT: d.key = fpec_pkg::KEY_LOCKOUT;
                           endcase
                        end
                     end
                     `FPEC_SFR_BANK:
                     begin
                        d.rdata = {6'h00, q.bank};
                        if (ifc.we)
                        begin
                           d.bank = ifc.wdata[1:0];
                        end
                     end
                     default: d.rdata = 8'h00;
                  endcase
               end
               // [RL19] reads go to ram
               else if (!ifc.we)
               begin
                  d.ra = ifc.addr;
                  d.rre = 1'b1;
                  d.op = fpec_pkg::OP_RAMRD;
               end
               // [RL5] enable steers to flash
               else if (!q.wen)
               begin
                  d.ra = ifc.addr;
                  d.rwd = ifc.wdata;
                  d.rwe = 1'b1;
                  d.ack = 1'b1;
               end
               // [RL7] supply monitor check
               else if (!(ifc.vmon_en && ifc.vmon_reset_en))
               begin
                  d.err = 1'b1;
                  d.ack = 1'b1;
               end
               // [RL10] early attempt locks out
               else if (q.key != fpec_pkg::KEY_UNLOCKED)
               begin
                  d.key = fpec_pkg::KEY_LOCKOUT;
                  d.ack = 1'b1;
               end
               // [RL18] erase needs both enables
               // [RL13] whole page, data ignored
               else if (q.een)
               begin
                  d.dbg = 1'b0;
                  d.fa = map_addr(q.bank, ifc.addr) & PAGE_MASK;
                  d.erase = 1'b1;
                  d.cnt = ERASE_CNT;
                  d.op = fpec_pkg::OP_ERASE;
               end
               // [RL1] byte from write operands
               else
               begin
                  d.dbg = 1'b0;
                  d.fa = map_addr(q.bank, ifc.addr);
                  d.fd = ifc.wdata;
                  d.op = fpec_pkg::OP_RDOLD;
               end
            end
         end
         fpec_pkg::OP_RAMRD:
         begin
            d.rdata = ram_rdata;
            d.ack = 1'b1;
            d.op = fpec_pkg::OP_IDLE;
         end
         fpec_pkg::OP_RDOLD:
         begin
            // [RL2] only clear bits
            d.fd = q.fd & fl_rdata;
            d.prog = 1'b1;
            d.cnt = PROG_CNT;
            d.op = fpec_pkg::OP_PROG;
         end
         fpec_pkg::OP_PROG, fpec_pkg::OP_ERASE:
         begin
            // [RL3] internal operation timer
            // [RL12] page erase held full time
            if (q.cnt == 21'h0_0001)
            begin
               d.prog = 1'b0;
               d.erase = 1'b0;
               d.op = fpec_pkg::OP_IDLE;
               d.dbg_ack = q.dbg;
               d.ack = !q.dbg;
               // [RL11] relock after operation
               if (!q.dbg && q.key == fpec_pkg::KEY_UNLOCKED)
                  d.key = fpec_pkg::KEY_LOCKED;
            end
            else
            begin
               d.cnt = q.cnt - 21'h0_0001;
            end
         end
         default: d.op = fpec_pkg::OP_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         q <= '0;
      else
         q <= d;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // [RL4] stall through flash operation
   assign ifc.stall = (q.op == fpec_pkg::OP_RDOLD) || (q.op == fpec_pkg::OP_PROG) ||
                      (q.op == fpec_pkg::OP_ERASE);
   assign ifc.ack = q.ack;
   assign ifc.rdata = q.rdata;
   assign ifc.dbg_ack = q.dbg_ack;
   assign fl_addr = q.fa;
   assign fl_wdata = q.fd;
   assign fl_prog = q.prog;
   assign fl_erase = q.erase;
   assign ram_addr = q.ra;
   assign ram_wdata = q.rwd;
   assign ram_we = q.rwe;
   assign ram_re = q.rre;
   assign flash_error_reset = q.err;
endmodule : fpec_dev

//--- rtl/fpec_host.sv
// core and debug side: wishbone command bridge and flash sequences
`timescale 1ns/1ps
`include "fpec_map.svh"
module fpec_host (
   input wire logic ref_clk,
   input wire logic reset,
   fpec_if.host ifc,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [31:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_wdata,
   output logic [31:0] wb_rdata,
   output logic wb_ack
);
   fpec_pkg::fpec_host_t q, d;

   // --------------------------------
   // sequence steps
   // --------------------------------
   // erase runs steps 0..6, byte program runs 1..6 with enables 1
   function automatic fpec_pkg::fpec_req_t seq_step(input logic erase, input logic [2:0] idx,
                                                    input logic [16:0] fa, input logic [7:0] fd);
      fpec_pkg::fpec_req_t r;
      logic [2:0] k;
      k = erase ? idx : idx + 3'h1;
      r = '{last: (k == `FPEC_SEQ_LAST), sfr: 1'b1, we: 1'b1, a: `FPEC_SFR_CONTROL, wd: 8'h00};
      unique case (k)
         3'h0: r.wd = 8'h02;
         3'h1: r.wd = erase ? 8'h03 : 8'h01;
         3'h2:
         begin
            r.a = `FPEC_SFR_BANK;
            r.wd = {6'h00, fa[16:15]};
         end
         3'h3:
         begin
            r.a = `FPEC_SFR_KEY;
            r.wd = `FPEC_KEY_FIRST;
         end
         3'h4:
         begin
            r.a = `FPEC_SFR_KEY;
            r.wd = `FPEC_KEY_SECOND;
         end
         3'h5:
         begin
            r.sfr = 1'b0;
            r.a = {|fa[16:15], fa[14:0]};
            r.wd = fd;
         end
         default: r.wd = 8'h00;
      endcase
      return r;
   endfunction : seq_step

   function automatic fpec_pkg::fpec_req_t raw_step(input logic [2:0] cmd,
                                                    input logic [16:0] fa, input logic [7:0] fd);
      fpec_pkg::fpec_req_t r;
      r.last = 1'b1;
      r.sfr = (cmd == `FPEC_CMD_SFR_WR) || (cmd == `FPEC_CMD_SFR_RD);
      r.we = (cmd == `FPEC_CMD_SFR_WR) || (cmd == `FPEC_CMD_X_WR);
      r.a = fa[15:0];
      r.wd = fd;
      return r;
   endfunction : raw_step

   // --------------------------------
   // next state
   // --------------------------------
   always_comb
   begin
      logic hit;
      logic go;
      logic is_seq;
      hit = wb_cyc && wb_stb && !q.wb_ack;
      go = 1'b0;
      is_seq = (q.cmd == `FPEC_CMD_PROG) || (q.cmd == `FPEC_CMD_ERASE);
      d = q;
      d.wb_ack = hit;
      if (hit && !wb_we)
      begin
         d.wb_rdata = 32'h0000_0000;
         if (wb_adr[31:4] == 28'h000_0000)
         begin
            unique case (wb_adr[3:0])
               `FPEC_WB_CTRL: d.wb_rdata = {23'h00_0000, q.vmon, 4'h0, q.cmd, 1'b0};
               `FPEC_WB_ADDR: d.wb_rdata = {15'h0000, q.addr};
               `FPEC_WB_DATA: d.wb_rdata = {24'h00_0000, q.data};
               `FPEC_WB_STATUS: d.wb_rdata = {16'h0000, q.rdata, 6'h00, ifc.stall,
                                              q.st != fpec_pkg::H_IDLE};
               default: d.wb_rdata = 32'h0000_0000;
            endcase
         end
      end
      if (hit && wb_we && wb_adr[31:4] == 28'h000_0000)
      begin
         unique case (wb_adr[3:0])
            `FPEC_WB_CTRL:
            begin
               if (wb_sel[1])
               begin
                  d.vmon = wb_wdata[8];
               end
               if (wb_sel[0] && q.st == fpec_pkg::H_IDLE)
               begin
                  d.cmd = wb_wdata[3:1];
                  go = wb_wdata[0];
               end
            end
            `FPEC_WB_ADDR: if (q.st == fpec_pkg::H_IDLE) d.addr = wb_wdata[16:0];
            `FPEC_WB_DATA: if (wb_sel[0] && q.st == fpec_pkg::H_IDLE) d.data = wb_wdata[7:0];
            default: ;
         endcase
      end
      unique case (q.st)
         fpec_pkg::H_IDLE:
         begin
            if (go)
            begin
               d.step = 3'h0;
               if (d.cmd >= `FPEC_CMD_DBG_PROG)
               begin
                  d.st = fpec_pkg::H_DBG;
                  d.dreq = 1'b1;
                  d.derase = (d.cmd == `FPEC_CMD_DBG_ERASE);
               end
               else
               begin
                  d.st = fpec_pkg::H_REQ;
                  d.req = 1'b1;
                  // [RL14] guided erase order
                  // [RL15] bank set before access
                  if (d.cmd == `FPEC_CMD_PROG || d.cmd == `FPEC_CMD_ERASE)
                     d.r = seq_step(d.cmd == `FPEC_CMD_ERASE, 3'h0, d.addr, d.data);
                  else
                     d.r = raw_step(d.cmd, d.addr, d.data);
               end
            end
         end
         fpec_pkg::H_REQ:
         begin
            if (ifc.ack)
            begin
               if (!q.r.we)
               begin
                  d.rdata = ifc.rdata;
               end
               if (is_seq && !q.r.last)
               begin
                  d.step = q.step + 3'h1;
                  d.r = seq_step(q.cmd == `FPEC_CMD_ERASE, d.step, q.addr, q.data);
               end
               else
               begin
                  d.req = 1'b0;
                  d.st = fpec_pkg::H_IDLE;
               end
            end
         end
         fpec_pkg::H_DBG:
         begin
            if (ifc.dbg_ack)
            begin
               d.dreq = 1'b0;
               d.st = fpec_pkg::H_IDLE;
            end
         end
         default: d.st = fpec_pkg::H_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         q <= '0;
      else
         q <= d;
   end

   // --------------------------------
   // outputs
   // --------------------------------
   assign ifc.req = q.req;
   assign ifc.sfr = q.r.sfr;
   assign ifc.we = q.r.we;
   assign ifc.addr = q.r.a;
   assign ifc.wdata = q.r.wd;
   // [RL17] monitor and reset source together
   assign ifc.vmon_en = q.vmon;
   assign ifc.vmon_reset_en = q.vmon;
   assign ifc.dbg_req = q.dreq;
   assign ifc.dbg_erase = q.derase;
   assign ifc.dbg_addr = q.addr;
   assign ifc.dbg_data = q.data;
   assign wb_ack = q.wb_ack;
   assign wb_rdata = q.wb_rdata;
endmodule : fpec_host

//--- rtl/fpec_if.sv
// link between the core or debug side and the flash controller
`timescale 1ns/1ps
interface fpec_if;
   logic req;
   logic sfr;
   logic we;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   logic stall;
   logic vmon_en;
   logic vmon_reset_en;
   logic dbg_req;
   logic dbg_erase;
   logic [16:0] dbg_addr;
   logic [7:0] dbg_data;
   logic dbg_ack;

   modport dev (
      input req, sfr, we, addr, wdata, vmon_en, vmon_reset_en,
      input dbg_req, dbg_erase, dbg_addr, dbg_data,
      output ack, rdata, stall, dbg_ack
   );
   modport host (
      output req, sfr, we, addr, wdata, vmon_en, vmon_reset_en,
      output dbg_req, dbg_erase, dbg_addr, dbg_data,
      input ack, rdata, stall, dbg_ack
   );
endinterface : fpec_if

//--- rtl/fpec_map.svh
// constants of the flash program and erase controller
`ifndef FPEC_MAP_SVH
`define FPEC_MAP_SVH
// --------------------------------
// key codes and control fields
// --------------------------------
`define FPEC_KEY_FIRST 8'ha5
`define FPEC_KEY_SECOND 8'hf1
`define FPEC_WE_BIT 0
`define FPEC_EE_BIT 1
`define FPEC_PAGE_BITS 10
`define FPEC_ERASED_BYTE 8'hff
// --------------------------------
// special function register selects on the core channel
// --------------------------------
`define FPEC_SFR_CONTROL 16'h0000
`define FPEC_SFR_KEY 16'h0001
`define FPEC_SFR_BANK 16'h0002
// --------------------------------
// timing
// --------------------------------
`define FPEC_CLK_MHZ 100
`define FPEC_PROG_TIME_NS 20000
`define FPEC_PROG_CYCLES ((`FPEC_PROG_TIME_NS * `FPEC_CLK_MHZ + 999) / 1000)
`define FPEC_ERASE_TIME_US 20000
`define FPEC_ERASE_CYCLES (`FPEC_ERASE_TIME_US * `FPEC_CLK_MHZ)
// --------------------------------
// host wishbone registers
// --------------------------------
`define FPEC_WB_CTRL 4'h0
`define FPEC_WB_ADDR 4'h4
`define FPEC_WB_DATA 4'h8
`define FPEC_WB_STATUS 4'hc
`define FPEC_CMD_SFR_WR 3'h0
`define FPEC_CMD_SFR_RD 3'h1
`define FPEC_CMD_X_WR 3'h2
`define FPEC_CMD_X_RD 3'h3
`define FPEC_CMD_PROG 3'h4
`define FPEC_CMD_ERASE 3'h5
`define FPEC_CMD_DBG_PROG 3'h6
`define FPEC_CMD_DBG_ERASE 3'h7
`define FPEC_SEQ_LAST 3'h6
`endif

//--- rtl/fpec_pkg.sv
// types of the flash program and erase controller
package fpec_pkg;
   typedef enum logic [1:0] {
      KEY_LOCKED = 2'b00,
      KEY_FIRST = 2'b01,
      KEY_UNLOCKED = 2'b10,
      KEY_LOCKOUT = 2'b11
   } fpec_key_t;

   typedef enum logic [2:0] {
      OP_IDLE = 3'b000,
      OP_RAMRD = 3'b001,
      OP_RDOLD = 3'b010,
      OP_PROG = 3'b011,
      OP_ERASE = 3'b100
   } fpec_op_t;

   typedef struct packed {
      fpec_key_t key;
      fpec_op_t op;
      logic wen;
      logic een;
      logic [1:0] bank;
      logic [20:0] cnt;
      logic [16:0] fa;
      logic [7:0] fd;
      logic dbg;
      logic ack;
      logic [7:0] rdata;
      logic dbg_ack;
      logic prog;
      logic erase;
      logic [15:0] ra;
      logic [7:0] rwd;
      logic rwe;
      logic rre;
      logic err;
   } fpec_dev_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_REQ = 2'b01,
      H_DBG = 2'b10
   } fpec_hst_t;

   typedef struct packed {
      logic last;
      logic sfr;
      logic we;
      logic [15:0] a;
      logic [7:0] wd;
   } fpec_req_t;

   typedef struct packed {
      fpec_hst_t st;
      logic [2:0] cmd;
      logic [16:0] addr;
      logic [7:0] data;
      logic [2:0] step;
      logic [7:0] rdata;
      logic vmon;
      logic req;
      fpec_req_t r;
      logic dreq;
      logic derase;
      logic wb_ack;
      logic [31:0] wb_rdata;
   } fpec_host_t;
endpackage : fpec_pkg

//--- tb/fpec_link_asserts.sv
// checker of the core and debug channel between the two controller ends
`timescale 1ns/1ps
module fpec_link_asserts #(
   parameter int ERASE_CYCLES = 20
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic req,
   input wire logic sfr,
   input wire logic we,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata,
   input wire logic stall,
   input wire logic vmon_en,
   input wire logic vmon_reset_en,
   input wire logic dbg_req,
   input wire logic dbg_erase,
   input wire logic [16:0] dbg_addr,
   input wire logic [7:0] dbg_data,
   input wire logic dbg_ack
);
   localparam int PROG_N = 2001;
   logic [11:0] scnt_q;
   logic [11:0] scnt_d;
   // --------------------------------
   // stall length counter
   // --------------------------------
   // a program stall is far beyond a plain delay
   always_comb scnt_d = stall ? scnt_q + 12'h001 : 12'h000;
   always_ff @(posedge ref_clk) scnt_q <= reset ? 12'h000 : scnt_d;
   // --------------------------------
   // properties
   // --------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("ack too long");
   dbg_pulse_a: assert property (dbg_ack |=> !dbg_ack)
      else $error("debug ack too long");
   req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata)
      && $stable(we) && $stable(sfr))
      else $error("request not held");
   dbg_hold_a: assert property (dbg_req && !dbg_ack |=> dbg_req && $stable(dbg_addr)
      && $stable(dbg_data) && $stable(dbg_erase))
      else $error("debug request not held");
   sfr_answer_a: assert property ($rose(req) && sfr && !stall && !dbg_req |=> ack)
      else $error("register access late");
   ram_read_a: assert property ($rose(req) && !sfr && !we && !stall && !dbg_req
      |=> !ack ##1 ack)
      else $error("ram read late");
   stall_free_a: assert property (ack |-> !stall)
      else $error("stall in ack cycle");
   stall_end_a: assert property ($fell(stall) |-> ack || dbg_ack)
      else $error("stall end without ack");
   stall_len_a: assert property ($fell(stall) |-> scnt_q == PROG_N
      || scnt_q == ERASE_CYCLES)
      else $error("operation time wrong");
   vmon_pair_a: assert property (vmon_en == vmon_reset_en)
      else $error("supply monitor enables differ");
   rdata_hold_a: assert property ($changed(rdata) |-> ack)
      else $error("rdata changed without ack");
   cover property ($fell(stall) && scnt_q == PROG_N);
   cover property ($fell(stall) && scnt_q == ERASE_CYCLES);
   cover property (dbg_ack);
   cover property (ack && sfr && we);
endmodule : fpec_link_asserts

//--- tb/tb_flash_program_erase_control.sv
// self-checking bench of both controller ends with flash and ram models
`timescale 1ns/1ps
module tb_flash_program_erase_control;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [31:0] wb_adr = 32'h0000_0000;
   logic [3:0] wb_sel = 4'hf;
   logic [31:0] wb_wdata = 32'h0000_0000;
   logic [31:0] wb_rdata;
   logic wb_ack;
   logic [16:0] fl_addr;
   logic [7:0] fl_wdata;
   logic fl_prog;
   logic fl_erase;
   logic [7:0] fl_rdata;
   logic [15:0] ram_addr;
   logic [7:0] ram_wdata;
   logic ram_we;
   logic ram_re;
   logic [7:0] ram_rdata;
   logic flash_error_reset;
   logic [7:0] fmem [131072];
   logic [7:0] external_data_ram [65536];
   logic [31:0] seed = 32'h0000_4d4a;
   logic [7:0] last;
   int n_fail = 0;
   int n_checks = 0;
   int n_err = 0;
   always #5 ref_clk = ~ref_clk;
   fpec_if u_fpec_if();
   fpec_host u_fpec_host (.ref_clk, .reset, .ifc(u_fpec_if), .wb_cyc, .wb_stb, .wb_we,
      .wb_adr, .wb_sel, .wb_wdata, .wb_rdata, .wb_ack);
   fpec_dev #(.ERASE_CYCLES(20)) u_fpec_dev (.ref_clk, .reset, .ifc(u_fpec_if), .fl_addr,
      .fl_wdata, .fl_prog, .fl_erase, .fl_rdata, .ram_addr, .ram_wdata, .ram_we, .ram_re,
      .ram_rdata, .flash_error_reset);
   fpec_link_asserts #(.ERASE_CYCLES(20)) u_fpec_link_asserts (.ref_clk, .reset,
      .req(u_fpec_if.req), .sfr(u_fpec_if.sfr), .we(u_fpec_if.we), .addr(u_fpec_if.addr),
      .wdata(u_fpec_if.wdata), .ack(u_fpec_if.ack), .rdata(u_fpec_if.rdata),
      .stall(u_fpec_if.stall), .vmon_en(u_fpec_if.vmon_en),
      .vmon_reset_en(u_fpec_if.vmon_reset_en), .dbg_req(u_fpec_if.dbg_req),
      .dbg_erase(u_fpec_if.dbg_erase), .dbg_addr(u_fpec_if.dbg_addr),
      .dbg_data(u_fpec_if.dbg_data), .dbg_ack(u_fpec_if.dbg_ack));
   // --------------------------------
   // flash macro and data ram models
   // --------------------------------
   assign fl_rdata = fmem[fl_addr];
   // read data stands only while the read strobe is high
   assign ram_rdata = ram_re ? external_data_ram[ram_addr] : 8'h00;
   always @(posedge ref_clk)
   begin
      if (fl_prog) fmem[fl_addr] <= fl_wdata;
      if (fl_erase) chk("erase base", {22'h0, fl_addr[9:0]}, 32'h0000_0000);
      if (fl_erase) for (int i = 0; i < 1024; i++) fmem[{fl_addr[16:10], i[9:0]}] <= 8'hff;
      if (ram_we) external_data_ram[ram_addr] <= ram_wdata;
      if (flash_error_reset) n_err++;
   end
   // --------------------------------
   // helpers
   // --------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [16:0] page(input logic [16:0] x);
      return {x[16:10], 10'h000};
   endfunction : page
   function automatic logic [7:0] prog_exp(input logic [7:0] o, input logic [7:0] n);
      return o & n;
   endfunction : prog_exp
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic rst();
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
   endtask : rst
   // request held up to the edge that samples ack
   task automatic wb(input logic w, input logic [31:0] ad, input logic [31:0] dt,
      output logic [31:0] q);
      @(posedge ref_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= ad;
      wb_wdata <= dt;
      do @(posedge ref_clk); while (wb_ack !== 1'b1);
      q = wb_rdata;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb
   task automatic run(input logic [2:0] c, input logic [16:0] a, input logic [7:0] d,
      input logic v);
      logic [31:0] q;
      wb(1'b1, 32'h0000_0004, {15'h0, a}, q);
      wb(1'b1, 32'h0000_0008, {24'h0, d}, q);
      wb(1'b1, 32'h0000_0000, {23'h0, v, 4'h0, c, 1'b1}, q);
      do wb(1'b0, 32'h0000_000c, 32'h0000_0000, q); while (q[0] !== 1'b0);
      last = q[15:8];
   endtask : run
   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   initial
   begin
      #500000;
      n_fail++;
      end_sim();
   end
   // --------------------------------
   // main sequence
   // --------------------------------
   initial
   begin
      logic [31:0] q;
      logic [16:0] a;
      logic [7:0] d;
      logic [7:0] d2;
      logic [7:0] k;
      int e0;
      for (int i = 0; i < 131072; i++) fmem[i] = 8'h3c;
      rst();
      q = xs();
      a = q[16:0];
      d = q[31:24];
      wb(1'b1, 32'h0000_0004, {15'h0, a}, q);
      wb(1'b0, 32'h0000_0004, 32'h0000_0000, q);
      chk("addr reg", q, {15'h0, a});
      wb(1'b0, 32'h0000_0010, 32'h0000_0000, q);
      chk("unmapped", q, 32'h0000_0000);
      run(3'h7, a, 8'h00, 1'b0);
      chk("debug erase", fmem[a], 8'hff);
      run(3'h4, a, d, 1'b1);
      chk("program", fmem[a], d);
      q = xs();
      d2 = q[7:0];
      run(3'h4, a, d2, 1'b1);
      chk("reprogram", fmem[a], prog_exp(d, d2));
      run(3'h1, 17'h1, 8'h00, 1'b0);
      chk("key relock", last, 8'h00);
      run(3'h5, a, d2, 1'b1);
      chk("erase low", fmem[page(a)], 8'hff);
      chk("erase high", fmem[page(a) | 17'h3ff], 8'hff);
      chk("erase other", fmem[a ^ 17'h0400], 8'h3c);
      run(3'h0, 17'h0, 8'h00, 1'b0);
      run(3'h2, a, d, 1'b0);
      chk("ram not flash", fmem[a], 8'hff);
      run(3'h0, 17'h0, 8'h01, 1'b0);
      run(3'h3, a, 8'h00, 1'b0);
      chk("ram read", last, d);
      run(3'h6, a, 8'h0f, 1'b0);
      run(3'h1, 17'h0, 8'h00, 1'b0);
      chk("we kept", last, 8'h01);
      chk("debug program", fmem[a], 8'h0f);
      e0 = n_err;
      run(3'h4, a, 8'h00, 1'b0);
      chk("supply error", n_err, e0 + 1);
      chk("supply no op", fmem[a], 8'h0f);
      // wrong value, wrong order, key while open, write before key
      for (int t = 0; t < 4; t++)
      begin
         rst();
         q = xs();
         k = (q[7:0] == 8'ha5) ? 8'h5a : q[7:0];
         if (t == 0) run(3'h0, 17'h1, k, 1'b0);
         if (t == 1) run(3'h0, 17'h1, 8'hf1, 1'b0);
         if (t == 2)
         begin
            run(3'h0, 17'h1, 8'ha5, 1'b0);
            run(3'h1, 17'h1, 8'h00, 1'b0);
            chk("key first", last, 8'h01);
            run(3'h0, 17'h1, 8'hf1, 1'b0);
            run(3'h1, 17'h1, 8'h00, 1'b0);
            chk("key open", last, 8'h02);
            run(3'h0, 17'h1, 8'hf1, 1'b0);
         end
         if (t == 3) run(3'h0, 17'h0, 8'h01, 1'b0);
         if (t == 3) run(3'h2, a, 8'h00, 1'b1);
         run(3'h1, 17'h1, 8'h00, 1'b0);
         chk("key lockout", last, 8'h03);
         run(3'h4, a, 8'h00, 1'b1);
         chk("locked program", fmem[a], 8'h0f);
      end
      rst();
      run(3'h1, 17'h1, 8'h00, 1'b0);
      chk("key after reset", last, 8'h00);
      end_sim();
   end
endmodule : tb_flash_program_erase_control
